// [endpoint_core.sv]
`timescale 1ns/10ps
module endpoint_core
	import endpoint_pkg::*;
#(
	parameter bit PASID_SUPPORTED = 1'b1,
	parameter bit XLAT_CACHE = 1'b0,
	parameter bit PAGE_REQ = 1'b0,
	parameter bit MULTI_FUNC_P2P = 1'b0,
	parameter bit PEER_P2P = 1'b0,
	parameter int MAX_OUT = MAX_OUTSTANDING
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Configuration from the root port and the function
	input wire logic [SPD_W-1:0] SPEED_VEC,
	input wire logic [BDF_W-1:0] BDF,
	input wire logic SEC_BUS_RESET,
	input wire logic LINK_DISABLE,
	input wire logic BUS_MASTER_EN,
	input wire logic FLR_START,
	input wire logic PWR_WE,
	input wire logic [1:0] PWR_STATE_IN,
	input wire logic PME_ENABLE,
	// Outbound requests from the function
	input wire out_req_t UREQ,
	input wire logic UREQ_VALID,
	output logic UREQ_READY,
	// Outbound requests to the link
	output link_req_t LREQ,
	output logic LREQ_VALID,
	input wire logic LREQ_READY,
	// Responses to outbound requests
	input wire logic RSP_VALID,
	input wire logic RSP_WRITE,
	// Inbound requests from the link
	input wire in_req_t IN_REQ,
	input wire logic IN_VALID,
	output logic IN_READY,
	// Inbound requests to the function
	output in_req_t USR_IN_REQ,
	output logic USR_IN_VALID,
	input wire logic USR_IN_DONE,
	input wire logic [DATA_W-1:0] USR_IN_DATA,
	// Completions to the link
	output cpl_t CPL,
	output logic CPL_VALID,
	input wire logic CPL_READY,
	// Interrupt and wake messages
	input wire logic MSI_REQ,
	input wire logic [MSI_VEC_W-1:0] MSI_VEC,
	input wire logic WAKE_REQ,
	output msg_t MSG,
	output logic MSG_VALID,
	input wire logic MSG_READY,
	// Status
	output logic TXN_PENDING,
	output logic HOT_RESET,
	output logic FUNC_RESET,
	output logic [1:0] PWR_STATE,
	output logic [7:0] INTR_PIN,
	output caps_t CAPS
);
	localparam int FLR_W = $clog2(FLR_CYCLES + 1);
	localparam logic [FLR_W-1:0] FLR_LOAD = FLR_W'(FLR_CYCLES);

	if (MAX_OUT < 1) begin : g_bad_max_out
		$error("endpoint_core needs MAX_OUT of at least 1");
	end

	// ============================================================
	// State
	typedef enum logic [2:0] {
		OUT_IDLE = 3'b001,
		OUT_FENCE = 3'b010,
		OUT_SEND = 3'b100
	} out_st_t;

	typedef enum logic [2:0] {
		IN_IDLE = 3'b001,
		IN_WAIT = 3'b010,
		IN_CPL = 3'b100
	} in_st_t;

	typedef struct packed {
		out_st_t ost;
		out_req_t hold;
		logic ureq_ready;
		logic lreq_valid;
		link_req_t lreq;
		in_st_t ist;
		in_req_t inq;
		logic in_ready;
		logic usr_in_valid;
		logic cpl_valid;
		cpl_t cpl;
		logic msi_pend;
		logic [MSI_VEC_W-1:0] msi_vec;
		logic pme_pend;
		logic msg_valid;
		msg_t msg;
		logic hot_rst;
		logic [FLR_W-1:0] flr_cnt;
		logic func_rst;
		logic [1:0] pwr;
		logic txn_pend;
		logic [7:0] intr_pin;
		caps_t caps;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic lreq_fire;
	logic rd_issue;
	logic wr_issue;
	logic rd_done;
	logic wr_done;
	logic rd_busy;
	logic rd_full;
	logic wr_busy;
	logic wr_full;
	logic spd8;
	logic spd16;

	function automatic logic read_like(input req_kind_t kind);
		return kind != KIND_WRITE;
	endfunction

	// Posted memory writes are the only inbound requests without a completion.
	function automatic logic needs_cpl(input in_req_t req);
		return !(req.space == SPACE_MEM && req.write);
	endfunction

	// ============================================================
	// Outstanding request tracking
	assign lreq_fire = st_q.lreq_valid && LREQ_READY;
	assign rd_issue = lreq_fire && read_like(st_q.lreq.req.kind);
	assign wr_issue = lreq_fire && !read_like(st_q.lreq.req.kind);
	assign rd_done = RSP_VALID && !RSP_WRITE;
	assign wr_done = RSP_VALID && RSP_WRITE;

	pending_tracker #(.DEPTH(MAX_OUT)) i_pending_tracker_rd (
		.clk(CLK),
		.rst(RST),
		.clr(st_q.func_rst),
		.issue(rd_issue),
		.done(rd_done),
		.busy(rd_busy),
		.full(rd_full)
	);

	pending_tracker #(.DEPTH(MAX_OUT)) i_pending_tracker_wr (
		.clk(CLK),
		.rst(RST),
		.clr(st_q.func_rst),
		.issue(wr_issue),
		.done(wr_done),
		.busy(wr_busy),
		.full(wr_full)
	);

	assign spd8 = |SPEED_VEC[SPD_W-1:SPD_8G_BIT];
	assign spd16 = |SPEED_VEC[SPD_W-1:SPD_16G_BIT];

	// ============================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.intr_pin = INTR_PIN_NONE;
		st_d.txn_pend = rd_busy || wr_busy;

		// Capability presence follows the declared speeds and features.
		st_d.caps.sec_pcie = spd8;
		st_d.caps.sec_regs = spd8 ? SEC_PCIE_REG_MASK : 4'h0;
		st_d.caps.dl_feature = spd16;
		st_d.caps.phy16 = spd16;
		st_d.caps.lane_margin = spd16;
		st_d.caps.dlf_regs = spd16 ? DLF_REG_MASK : 3'h0;
		st_d.caps.phy16_regs = spd16 ? PHY16_REG_MASK : 7'h00;
		st_d.caps.lmr_regs = spd16 ? LMR_REG_MASK : 5'h00;
		st_d.caps.ats = XLAT_CACHE;
		st_d.caps.pri = PAGE_REQ;
		st_d.caps.acs_ep = MULTI_FUNC_P2P;
		st_d.caps.aer_ep = MULTI_FUNC_P2P;
		st_d.caps.acs_rp = PEER_P2P;
		st_d.caps.aer_rp = PEER_P2P;
		st_d.caps.pm = 1'b1;
		st_d.caps.flr = 1'b1;

		// Reset sources.
		st_d.hot_rst = SEC_BUS_RESET || LINK_DISABLE;
		if (FLR_START) begin
			st_d.flr_cnt = FLR_LOAD;
		end else if (st_q.flr_cnt != '0) begin
			st_d.flr_cnt = st_q.flr_cnt - 1'b1;
		end
		st_d.func_rst = st_q.hot_rst || (st_q.flr_cnt != '0);

		if (PWR_WE) begin
			st_d.pwr = PWR_STATE_IN;
		end

		// Outbound path: one request held at a time keeps issue in order; up to MAX_OUT reads and atomics together and MAX_OUT writes may be outstanding.
		case (st_q.ost)
			OUT_IDLE: begin
				st_d.ureq_ready = 1'b1;
				if (UREQ_VALID && st_q.ureq_ready) begin
					st_d.hold = UREQ;
					st_d.ureq_ready = 1'b0;
					st_d.ost = OUT_FENCE;
				end
			end
			OUT_FENCE: begin
				// A dependent read waits until every earlier write is answered.
				if (BUS_MASTER_EN && st_q.pwr == PWR_D0 &&
						!(read_like(st_q.hold.kind) && st_q.hold.raw_dep && wr_busy) &&
						!(read_like(st_q.hold.kind) ? rd_full : wr_full)) begin
					st_d.lreq.req = st_q.hold;
					st_d.lreq.stream_id = BDF;
					st_d.lreq.substream_valid = PASID_SUPPORTED && st_q.hold.pasid_en;
					st_d.lreq.substream_id = st_q.hold.pasid;
					st_d.lreq_valid = 1'b1;
					st_d.ost = OUT_SEND;
				end
			end
			OUT_SEND: begin
				if (lreq_fire) begin
					st_d.lreq_valid = 1'b0;
					st_d.ureq_ready = 1'b1;
					st_d.ost = OUT_IDLE;
				end
			end
			default: begin
				st_d.ost = OUT_IDLE;
				st_d.lreq_valid = 1'b0;
				st_d.ureq_ready = 1'b0;
			end
		endcase

		// Inbound path: one access at a time, answered (a posted write only handed to the function) before the next.
		case (st_q.ist)
			IN_IDLE: begin
				st_d.in_ready = 1'b1;
				if (IN_VALID && st_q.in_ready) begin
					st_d.inq = IN_REQ;
					st_d.in_ready = 1'b0;
					if (IN_REQ.space == SPACE_IO) begin
						st_d.cpl = '{tag: IN_REQ.tag, status: CPL_UR, data: '0};
						st_d.cpl_valid = 1'b1;
						st_d.ist = IN_CPL;
					end else begin
						st_d.usr_in_valid = 1'b1;
						st_d.ist = IN_WAIT;
					end
				end
			end
			IN_WAIT: begin
				if (USR_IN_DONE) begin
					st_d.usr_in_valid = 1'b0;
					if (needs_cpl(st_q.inq)) begin
						st_d.cpl.tag = st_q.inq.tag;
						st_d.cpl.status = CPL_SC;
						st_d.cpl.data = st_q.inq.write ? '0 : USR_IN_DATA;
						st_d.cpl_valid = 1'b1;
						st_d.ist = IN_CPL;
					end else begin
						st_d.ist = IN_IDLE;
					end
				end
			end
			IN_CPL: begin
				if (CPL_READY && st_q.cpl_valid) begin
					st_d.cpl_valid = 1'b0;
					st_d.ist = IN_IDLE;
				end
			end
			default: begin
				st_d.ist = IN_IDLE;
				st_d.in_ready = 1'b0;
				st_d.usr_in_valid = 1'b0;
				st_d.cpl_valid = 1'b0;
			end
		endcase

		// Messages: wake first, interrupts only in D0. A second interrupt
		// before the first is sent overwrites its vector; one slot saves area.
		if (st_q.msg_valid && MSG_READY) begin
			st_d.msg_valid = 1'b0;
		end else if (!st_q.msg_valid) begin
			if (st_q.pme_pend) begin
				st_d.msg = '{kind: MSG_PME, vector: '0};
				st_d.msg_valid = 1'b1;
				st_d.pme_pend = 1'b0;
			end else if (st_q.msi_pend && st_q.pwr == PWR_D0) begin
				st_d.msg = '{kind: MSG_MSI, vector: st_q.msi_vec};
				st_d.msg_valid = 1'b1;
				st_d.msi_pend = 1'b0;
			end
		end
		// New events are taken after the clears so that the set wins.
		if (MSI_REQ) begin
			st_d.msi_pend = 1'b1;
			st_d.msi_vec = MSI_VEC;
		end
		if (WAKE_REQ && PME_ENABLE) begin
			st_d.pme_pend = 1'b1;
		end

		// Function reset aborts both paths and returns the function to D0.
		if (st_q.func_rst) begin
			st_d.ost = OUT_IDLE;
			st_d.ureq_ready = 1'b0;
			st_d.lreq_valid = 1'b0;
			st_d.ist = IN_IDLE;
			st_d.in_ready = 1'b0;
			st_d.usr_in_valid = 1'b0;
			st_d.cpl_valid = 1'b0;
			st_d.msi_pend = 1'b0;
			st_d.pme_pend = 1'b0;
			st_d.msg_valid = 1'b0;
			st_d.pwr = PWR_D0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_q <= '0;
			st_q.ost <= OUT_IDLE;
			st_q.ist <= IN_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ============================================================
	// Outputs
	assign UREQ_READY = st_q.ureq_ready;
	assign LREQ = st_q.lreq;
	assign LREQ_VALID = st_q.lreq_valid;
	assign IN_READY = st_q.in_ready;
	assign USR_IN_REQ = st_q.inq;
	assign USR_IN_VALID = st_q.usr_in_valid;
	assign CPL = st_q.cpl;
	assign CPL_VALID = st_q.cpl_valid;
	assign MSG = st_q.msg;
	assign MSG_VALID = st_q.msg_valid;
	assign TXN_PENDING = st_q.txn_pend;
	assign HOT_RESET = st_q.hot_rst;
	assign FUNC_RESET = st_q.func_rst;
	assign PWR_STATE = st_q.pwr;
	assign INTR_PIN = st_q.intr_pin;
	assign CAPS = st_q.caps;

	// ============================================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_caps_8g: assert property (SPEED_VEC[SPD_8G_BIT] |=>
		CAPS.sec_pcie && CAPS.sec_regs == SEC_PCIE_REG_MASK)
		else $error("secondary capability missing at 8GT/s");
	a_caps_16g: assert property (SPEED_VEC[SPD_16G_BIT] |=>
		CAPS.dl_feature && CAPS.phy16 && CAPS.lane_margin &&
		CAPS.dlf_regs == DLF_REG_MASK && CAPS.phy16_regs == PHY16_REG_MASK &&
		CAPS.lmr_regs == LMR_REG_MASK)
		else $error("16GT/s capabilities missing");
	a_acs_aer: assert property ((CAPS.acs_ep |-> CAPS.aer_ep) and
		(CAPS.acs_rp |-> CAPS.aer_rp))
		else $error("access control without error reporting");
	a_no_wired_irq: assert property ($rose(MSG_VALID) && MSG.kind == MSG_MSI |->
		$past(PWR_STATE) == PWR_D0 && INTR_PIN == INTR_PIN_NONE)
		else $error("interrupt outside message path");
	a_in_order: assert property (CPL_VALID |-> !IN_READY && !USR_IN_VALID)
		else $error("new inbound access taken before completion");
	a_raw_fence: assert property ($rose(LREQ_VALID) && LREQ.req.raw_dep &&
		read_like(LREQ.req.kind) |-> !$past(wr_busy))
		else $error("dependent read passed outstanding writes");
	a_pend_clear: assert property ($fell(TXN_PENDING) |-> !$past(rd_busy) && !$past(wr_busy))
		else $error("pending flag cleared with responses outstanding");
	a_pend_set: assert property (lreq_fire && !FUNC_RESET |-> ##2 TXN_PENDING)
		else $error("issued request not shown as pending");
	a_stream_ids: assert property ($rose(LREQ_VALID) |-> LREQ.stream_id == $past(BDF) &&
		LREQ.substream_valid == (PASID_SUPPORTED && LREQ.req.pasid_en) &&
		LREQ.substream_id == LREQ.req.pasid)
		else $error("translation identifiers wrong");
	a_flr_hold: assert property (FLR_START |-> ##2 FUNC_RESET [*2])
		else $error("function reset not held after FLR");
	a_hot_reset: assert property (LINK_DISABLE |=> HOT_RESET ##1 FUNC_RESET)
		else $error("hot reset not driven into endpoint");
	a_io_ur: assert property (IN_VALID && IN_READY && IN_REQ.space == SPACE_IO &&
		!FUNC_RESET |=> CPL_VALID && CPL.status == CPL_UR && !USR_IN_VALID)
		else $error("I/O request not refused");

	c_fence_wait: cover property (st_q.ost == OUT_FENCE && wr_busy ##1 st_q.ost == OUT_FENCE);
	c_io_refused: cover property (CPL_VALID && CPL.status == CPL_UR);
	c_pme_sent: cover property (MSG_VALID && MSG.kind == MSG_PME && MSG_READY);
	c_pend_drop: cover property ($fell(TXN_PENDING));

endmodule // endpoint_core

// [endpoint_pkg.sv]
// ============================================================
// Widths and field layouts
package endpoint_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 32;
	localparam int PASID_W = 20;
	localparam int TAG_W = 8;
	localparam int BDF_W = 16;
	localparam int SPD_W = 7;
	localparam int MSI_VEC_W = 5;
	localparam int MAX_OUTSTANDING = 32;

	// Bit positions in the supported-speed vector (bit 0 is 2.5 GT/s).
	localparam int SPD_8G_BIT = 2;
	localparam int SPD_16G_BIT = 3;

	// Register sets present inside each extended capability.
	localparam logic [3:0] SEC_PCIE_REG_MASK = 4'hf;
	localparam logic [2:0] DLF_REG_MASK = 3'h7;
	localparam logic [6:0] PHY16_REG_MASK = 7'h7f;
	localparam logic [4:0] LMR_REG_MASK = 5'h1f;

	// ============================================================
	// Encodings and reset values
	localparam logic [1:0] PWR_D0 = 2'h0;
	localparam logic [2:0] CPL_SC = 3'h0;
	localparam logic [2:0] CPL_UR = 3'h1;
	localparam logic [7:0] INTR_PIN_NONE = 8'h00;

	// ============================================================
	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int FLR_HOLD_NS = 1000;
	localparam int FLR_CYCLES_RAW = (FLR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLR_CYCLES = (FLR_CYCLES_RAW < 1) ? 1 : FLR_CYCLES_RAW;

	// ============================================================
	// Carriers
	typedef enum logic [2:0] {
		KIND_READ = 3'b001,
		KIND_WRITE = 3'b010,
		KIND_ATOMIC = 3'b100
	} req_kind_t;

	typedef enum logic [1:0] {
		SPACE_CFG = 2'h0,
		SPACE_MEM = 2'h1,
		SPACE_IO = 2'h2
	} space_t;

	typedef enum logic [1:0] {
		MSG_MSI = 2'b01,
		MSG_PME = 2'b10
	} msg_kind_t;

	typedef struct packed {
		req_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [TAG_W-1:0] tag;
		logic raw_dep;
		logic pasid_en;
		logic [PASID_W-1:0] pasid;
	} out_req_t;

	typedef struct packed {
		out_req_t req;
		logic [BDF_W-1:0] stream_id;
		logic substream_valid;
		logic [PASID_W-1:0] substream_id;
	} link_req_t;

	typedef struct packed {
		space_t space;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [TAG_W-1:0] tag;
	} in_req_t;

	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic [2:0] status;
		logic [DATA_W-1:0] data;
	} cpl_t;

	typedef struct packed {
		msg_kind_t kind;
		logic [MSI_VEC_W-1:0] vector;
	} msg_t;

	typedef struct packed {
		logic sec_pcie;
		logic dl_feature;
		logic phy16;
		logic lane_margin;
		logic ats;
		logic pri;
		logic acs_ep;
		logic aer_ep;
		logic acs_rp;
		logic aer_rp;
		logic pm;
		logic flr;
		logic [3:0] sec_regs;
		logic [2:0] dlf_regs;
		logic [6:0] phy16_regs;
		logic [4:0] lmr_regs;
	} caps_t;

endpackage : endpoint_pkg

// [pending_tracker.sv]
`timescale 1ns/10ps
// ============================================================
// Outstanding request counter
module pending_tracker
	import endpoint_pkg::*;
#(
	parameter int DEPTH = MAX_OUTSTANDING
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Counting events
	input wire logic clr,
	input wire logic issue,
	input wire logic done,
	// Status
	output logic busy,
	output logic full
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_MAX = CW'(DEPTH);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic busy;
		logic full;
	} trk_t;

	trk_t st_q;
	trk_t st_d;
	logic inc;
	logic dec;

	if (DEPTH < 1) begin : g_bad_depth
		$error("pending_tracker needs DEPTH of at least 1");
	end

	// An issue while full is dropped; the owner gates issue with full.
	assign inc = issue && (st_q.cnt != CNT_MAX);
	// A stray response with nothing outstanding must not wrap the count.
	assign dec = done && (st_q.cnt != '0);

	always_comb begin
		st_d = st_q;
		if (clr) begin
			st_d.cnt = '0;
		end else if (inc && !dec) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (dec && !inc) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
		st_d.busy = (st_d.cnt != '0);
		st_d.full = (st_d.cnt == CNT_MAX);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign busy = st_q.busy;
	assign full = st_q.full;

	// ============================================================
	// Checks
	a_issue_busy: assert property (@(posedge clk) disable iff (rst)
		issue && !clr && !full |=> busy)
		else $error("issued request not counted as outstanding");
	a_last_done: assert property (@(posedge clk) disable iff (rst)
		st_q.cnt == CW'(1) && done && !issue |=> !busy)
		else $error("busy kept after last response");

endmodule // pending_tracker

// [link_partner.sv]
`timescale 1ns/10ps
// ============================================================
// Root port side: takes requests, answers them, sinks messages
module link_partner
	import endpoint_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Bench controls
	input wire logic slow,
	input wire logic hold,
	// Link side of the endpoint
	input wire link_req_t LREQ,
	input wire logic LREQ_VALID,
	output logic LREQ_READY,
	output logic RSP_VALID,
	output logic RSP_WRITE,
	output logic CPL_READY,
	output logic MSG_READY
);
	logic [15:0] lf_q;
	bit wr_q[$];

	// Answers leave in issue order, so writes are observed in the order they were sent.
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			lf_q <= 16'h0001;
			wr_q.delete();
			LREQ_READY <= 1'b0;
			RSP_VALID <= 1'b0;
			RSP_WRITE <= 1'b0;
			CPL_READY <= 1'b0;
			MSG_READY <= 1'b0;
		end else begin
			lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
			LREQ_READY <= !slow || lf_q[0];
			CPL_READY <= !slow || lf_q[1];
			MSG_READY <= !slow || lf_q[2];
			RSP_VALID <= 1'b0;
			// An idle response line carries noise so a stale kind is never trusted.
			RSP_WRITE <= lf_q[4];
			if (!hold && wr_q.size() > 0 && (!slow || lf_q[3])) begin
				RSP_VALID <= 1'b1;
				RSP_WRITE <= wr_q.pop_front();
			end
			if (LREQ_VALID && LREQ_READY)
				wr_q.push_back(LREQ.req.kind == KIND_WRITE);
		end
	end
endmodule // link_partner

// [tb_endpoint_core.sv]
`timescale 1ns/10ps
// ============================================================
// Self-checking bench for the endpoint core
module tb_endpoint_core;
	import endpoint_pkg::*;

	logic clk = 1'b0, rst = 1'b1, slow = 1'b0, hold = 1'b0;
	logic [SPD_W-1:0] speed_vec = '0;
	logic [BDF_W-1:0] bdf = '0;
	logic sec_bus_reset = 1'b0, link_disable = 1'b0, flr_start = 1'b0;
	logic pwr_we = 1'b0, pme_enable = 1'b0, ureq_valid = 1'b0, in_valid = 1'b0;
	logic usr_in_done = 1'b0, msi_req = 1'b0, wake_req = 1'b0;
	logic [1:0] pwr_state_in = '0;
	out_req_t ureq = '0;
	in_req_t in_req = '0;
	logic [DATA_W-1:0] usr_in_data = '0;
	logic [MSI_VEC_W-1:0] msi_vec = '0;
	link_req_t lreq;
	in_req_t usr_in_req;
	cpl_t cpl;
	msg_t msg;
	caps_t caps;
	logic ureq_ready, lreq_valid, lreq_ready, rsp_valid, rsp_write, in_ready;
	logic usr_in_valid, cpl_valid, cpl_ready, msg_valid, msg_ready;
	logic txn_pending, hot_reset, func_reset;
	logic [1:0] pwr_state;
	logic [7:0] intr_pin;
	int n_errors = 0, comparisons = 0, cycles = 0;
	int out_cnt = 0, wr_cnt = 0, prev_out = 0;
	logic [15:0] lfsr = 16'h9e88;
	out_req_t exp_q[$];
	out_req_t e;

	always #25 clk = ~clk;

	endpoint_core #(.XLAT_CACHE(1'b1), .MULTI_FUNC_P2P(1'b1)) i_endpoint_core (
		.CLK(clk), .RST(rst), .SPEED_VEC(speed_vec), .BDF(bdf),
		.SEC_BUS_RESET(sec_bus_reset), .LINK_DISABLE(link_disable),
		.BUS_MASTER_EN(1'b1), .FLR_START(flr_start), .PWR_WE(pwr_we),
		.PWR_STATE_IN(pwr_state_in), .PME_ENABLE(pme_enable),
		.UREQ(ureq), .UREQ_VALID(ureq_valid), .UREQ_READY(ureq_ready),
		.LREQ(lreq), .LREQ_VALID(lreq_valid), .LREQ_READY(lreq_ready),
		.RSP_VALID(rsp_valid), .RSP_WRITE(rsp_write),
		.IN_REQ(in_req), .IN_VALID(in_valid), .IN_READY(in_ready),
		.USR_IN_REQ(usr_in_req), .USR_IN_VALID(usr_in_valid),
		.USR_IN_DONE(usr_in_done), .USR_IN_DATA(usr_in_data),
		.CPL(cpl), .CPL_VALID(cpl_valid), .CPL_READY(cpl_ready),
		.MSI_REQ(msi_req), .MSI_VEC(msi_vec), .WAKE_REQ(wake_req),
		.MSG(msg), .MSG_VALID(msg_valid), .MSG_READY(msg_ready),
		.TXN_PENDING(txn_pending), .HOT_RESET(hot_reset), .FUNC_RESET(func_reset),
		.PWR_STATE(pwr_state), .INTR_PIN(intr_pin), .CAPS(caps)
	);

	link_partner i_link_partner (
		.CLK(clk), .RST(rst), .slow(slow), .hold(hold), .LREQ(lreq),
		.LREQ_VALID(lreq_valid), .LREQ_READY(lreq_ready), .RSP_VALID(rsp_valid),
		.RSP_WRITE(rsp_write), .CPL_READY(cpl_ready), .MSG_READY(msg_ready)
	);

	// ============================================================
	// Helpers
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	function automatic caps_t exp_caps(input logic [SPD_W-1:0] s);
		caps_t c;
		c = '0;
		c.sec_pcie = |s[SPD_W-1:SPD_8G_BIT];
		c.dl_feature = |s[SPD_W-1:SPD_16G_BIT];
		c.phy16 = c.dl_feature;
		c.lane_margin = c.dl_feature;
		c.ats = 1'b1;
		c.acs_ep = 1'b1;
		c.aer_ep = 1'b1;
		c.pm = 1'b1;
		c.flr = 1'b1;
		c.sec_regs = {4{c.sec_pcie}};
		c.dlf_regs = {3{c.dl_feature}};
		c.phy16_regs = {7{c.dl_feature}};
		c.lmr_regs = {5{c.dl_feature}};
		return c;
	endfunction

	task automatic chk(input logic ok, input string what);
		comparisons++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask

	task automatic conclude();
		$display("errors %0d, comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
	endtask

	function automatic logic hs_ok(input int w);
		case (w)
			0: return ureq_ready === 1'b1;
			1: return in_ready === 1'b1;
			2: return usr_in_valid === 1'b1;
			3: return cpl_valid === 1'b1 && cpl_ready === 1'b1;
			default: return msg_valid === 1'b1 && msg_ready === 1'b1;
		endcase
	endfunction

	// Waits for a handshake edge; the caller reads what it carries before moving on.
	task automatic hs(input int w);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (!hs_ok(w) && k < 300);
		// A handshake that never comes must not let a later check pass by luck.
		if (!hs_ok(w)) begin
			n_errors++;
			$display("MISMATCH at %0t: handshake %0d timed out", $time, w);
		end
	endtask

	task automatic inbound(input in_req_t r, input logic [DATA_W-1:0] d);
		in_req = r;
		in_valid = 1'b1;
		hs(1);
		#1 in_valid = 1'b0;
		if (r.space != SPACE_IO) begin
			hs(2);
			#1;
			chk(usr_in_req === r, "inbound request");
			usr_in_data = d;
			pulse(usr_in_done);
		end
		if (r.space == SPACE_MEM && r.write) begin
			step(4);
			chk(cpl_valid === 1'b0, "posted write completed");
		end else begin
			hs(3);
			chk(cpl.tag === r.tag, "completion tag");
			if (r.space == SPACE_IO)
				chk(cpl.status === CPL_UR, "io access accepted");
			else
				chk(cpl.status === CPL_SC && cpl.data === (r.write ? '0 : d), "completion");
			#1;
		end
	endtask

	// ============================================================
	// Outbound monitor and hang guard
	always @(posedge clk) begin
		cycles++;
		if (func_reset !== 1'b0) begin
			exp_q.delete();
			out_cnt = 0;
			wr_cnt = 0;
			prev_out = 0;
		end else begin
			if (prev_out > 0)
				chk(txn_pending === 1'b1, "pending cleared early");
			prev_out = out_cnt;
			if (rsp_valid === 1'b1 && out_cnt > 0) begin
				out_cnt--;
				if (rsp_write === 1'b1)
					wr_cnt--;
			end
			if (lreq_valid === 1'b1 && lreq_ready === 1'b1) begin
				chk(exp_q.size() > 0, "extra link request");
				if (exp_q.size() > 0)
					e = exp_q.pop_front();
				chk(lreq.req === e, "outbound order");
				chk(lreq.stream_id === bdf, "stream id");
				chk(lreq.substream_valid === e.pasid_en, "substream flag");
				chk(!e.pasid_en || lreq.substream_id === e.pasid, "substream id");
				chk(!(e.raw_dep && e.kind != KIND_WRITE && wr_cnt > 0), "read passed write");
				out_cnt++;
				if (e.kind == KIND_WRITE)
					wr_cnt++;
			end
			if (ureq_valid === 1'b1 && ureq_ready === 1'b1)
				exp_q.push_back(ureq);
		end
		if (cycles == 20000) begin
			n_errors++;
			$display("MISMATCH at %0t: run timed out", $time);
			conclude();
		end
	end

	// ============================================================
	// Scenarios
	initial begin
		in_req_t ir;
		out_req_t r;
		msg_t m;
		logic [SPD_W-1:0] sv;
		logic [MSI_VEC_W-1:0] v;
		logic [15:0] x;
		int n;
		step(10);
		rst = 1'b0;
		step(2);
		chk(intr_pin === INTR_PIN_NONE, "wired interrupt");
		for (int i = 0; i < 8; i++) begin
			sv = (i < 4) ? SPD_W'((1 << (i + 1)) - 1) : SPD_W'(rnd());
			speed_vec = sv;
			step(2);
			chk(caps === exp_caps(sv), "capabilities");
		end
		for (int i = 0; i < 12; i++) begin
			slow = (i >= 6);
			ir.space = space_t'((i % 6) / 2);
			ir.write = i[0];
			ir.addr = {rnd(), rnd()};
			ir.data = {rnd(), rnd()};
			ir.tag = 8'(rnd());
			inbound(ir, {rnd(), rnd()});
		end
		for (int i = 0; i < 4; i++) begin
			v = MSI_VEC_W'(rnd());
			msi_vec = v;
			pulse(msi_req);
			hs(4);
			chk(msg === {MSG_MSI, v}, "msi message");
			#1;
		end
		pme_enable = 1'b1;
		msi_req = 1'b1;
		wake_req = 1'b1;
		step();
		msi_req = 1'b0;
		wake_req = 1'b0;
		hs(4);
		chk(msg.kind === MSG_PME, "wake message");
		hs(4);
		chk(msg === {MSG_MSI, v}, "msi after wake");
		#1;
		pme_enable = 1'b0;
		pwr_state_in = 2'h3;
		pulse(pwr_we);
		step();
		chk(pwr_state === 2'h3, "power state");
		pulse(wake_req);
		pulse(msi_req);
		step(10);
		chk(msg_valid === 1'b0, "message while asleep");
		pwr_state_in = PWR_D0;
		pulse(pwr_we);
		hs(4);
		chk(msg === {MSG_MSI, v}, "held msi");
		#1;
		bdf = rnd();
		for (int i = 0; i < 40; i++) begin
			slow = i[3];
			x = rnd();
			r.kind = x[1:0] == 2'h0 ? KIND_READ : (x[1:0] == 2'h1 ? KIND_ATOMIC : KIND_WRITE);
			r.addr = {rnd(), rnd()};
			r.data = {rnd(), rnd()};
			r.tag = 8'(i);
			r.raw_dep = x[2];
			r.pasid_en = x[3];
			r.pasid = {x[7:4], rnd()};
			ureq = r;
			ureq_valid = 1'b1;
			hs(0);
			#1;
		end
		ureq_valid = 1'b0;
		step(80);
		chk(txn_pending === 1'b0 && exp_q.size() == 0, "traffic left over");
		slow = 1'b0;
		hold = 1'b1;
		r.kind = KIND_WRITE;
		ureq = r;
		ureq_valid = 1'b1;
		hs(0);
		#1;
		r.kind = KIND_READ;
		r.raw_dep = 1'b1;
		ureq = r;
		hs(0);
		#1 ureq_valid = 1'b0;
		step(20);
		chk(lreq_valid === 1'b0 && ureq_ready === 1'b0, "dependent read passed write");
		chk(txn_pending === 1'b1, "pending with write open");
		hold = 1'b0;
		step(20);
		chk(txn_pending === 1'b0 && exp_q.size() == 0, "fence stuck");
		sec_bus_reset = 1'b1;
		step();
		chk(hot_reset === 1'b1, "no hot reset");
		sec_bus_reset = 1'b0;
		link_disable = 1'b1;
		for (int i = 0; i < 8; i++) begin
			step();
			chk(hot_reset === 1'b1 && func_reset === 1'b1 && (i == 0 || in_ready === 1'b0), "reset let go");
		end
		link_disable = 1'b0;
		step(3);
		chk(hot_reset === 1'b0 && func_reset === 1'b0, "reset stuck");
		pwr_state_in = 2'h2;
		pulse(pwr_we);
		pulse(flr_start);
		n = 0;
		for (int i = 0; i < 60; i++) begin
			step();
			if (func_reset === 1'b1)
				n++;
		end
		chk(n == FLR_CYCLES, "function reset length");
		chk(pwr_state === PWR_D0, "power state after reset");
		conclude();
	end
endmodule // tb_endpoint_core
